// ==== verilog/cct_pkg.sv ====
/*
  Shared constants and types of the calendar cam timer: register map,
  field layout, reset values and the cam and date records.
  Assumes the calendar year is given as an offset from the year 2000.
*/
package cct_pkg;
  // ***********************************************
  // sizes and calendar limits
  // ***********************************************
  localparam int CAM_COUNT = 3;
  localparam int TIME_W = 11;
  localparam int DAYS_PER_WEEK = 7;
  localparam logic [2:0] WEEKDAY_LAST = 3'h6;
  localparam logic [TIME_W-1:0] TIME_UNSET = 11'h7FF;
  localparam logic [TIME_W-1:0] MIN_PER_HOUR = 11'h03C;
  localparam logic [6:0] YEAR_MAX = 7'h63;
  localparam logic [4:0] HOUR_MIDNIGHT = 5'h00;
  localparam logic [5:0] MINUTE_ZERO = 6'h00;

  // ***********************************************
  // register map (byte addresses) and fields
  // ***********************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CAM0 = 8'h04;
  localparam logic [7:0] OFS_CAM1 = 8'h08;
  localparam logic [7:0] OFS_CAM2 = 8'h0C;
  localparam logic [7:0] OFS_YON = 8'h10;
  localparam logic [7:0] OFS_YOFF = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam int CTRL_WK_PULSE = 0;
  localparam int CTRL_Y_MONTHLY = 1;
  localparam int CTRL_Y_YEARLY = 2;
  localparam int CTRL_Y_PULSE = 3;
  localparam int STAT_WK = 0;
  localparam int STAT_YR = 1;
  localparam int CAM_MASK_LSB = 0;
  localparam int CAM_ON_LSB = 8;
  localparam int CAM_OFF_LSB = 20;
  localparam int DATE_YEAR_LSB = 0;
  localparam int DATE_MON_LSB = 8;
  localparam int DATE_DAY_LSB = 16;

  // ***********************************************
  // records
  // ***********************************************
  typedef struct packed {
    logic [DAYS_PER_WEEK-1:0] mask;
    logic [TIME_W-1:0] on_min;
    logic [TIME_W-1:0] off_min;
  } cct_cam_t;
  typedef cct_cam_t [CAM_COUNT-1:0] cct_cams_t;
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
  } cct_date_t;

  localparam cct_cam_t CAM_RESET = '{mask: 7'h00, on_min: TIME_UNSET, off_min: TIME_UNSET};
  localparam cct_date_t DATE_RESET = '{year: 7'h00, month: 4'h1, day: 5'h01};
endpackage

// ==== verilog/cct_cal_if.sv ====
/*
  Calendar snapshot handed from the top to both cam sub-modules.
  Assumes the top fills it straight from the real-time clock inputs.
*/
`timescale 1ns/1ps
interface cct_cal_if;
  logic tick;
  logic [cct_pkg::TIME_W-1:0] minute;
  logic [2:0] weekday;
  cct_pkg::cct_date_t date;
  logic midnight;
  modport src (output tick, minute, weekday, date, midnight);
  modport sink (input tick, minute, weekday, date, midnight);
endinterface

// ==== verilog/cct_weekly.sv ====
/*
  Weekly sub-module: three cams with weekday mask and on/off minute.
  Assumes one program cycle tick pulse and a valid calendar snapshot.
*/
`timescale 1ns/1ps
module cct_weekly (
  input wire logic clk,
  input wire logic rst,
  cct_cal_if.sink cal,
  input wire cct_pkg::cct_cams_t cams,
  input wire logic pulse_mode,
  output logic q
);
  typedef struct packed {
    logic out;
    logic [cct_pkg::TIME_W-1:0] last_min;
  } cct_wk_state_t;

  cct_wk_state_t st;
  cct_wk_state_t next_st;
  logic fresh;
  logic any_on;
  logic any_off;

  // a cam fires on a weekday it selects, at a set time equal to now
  function automatic logic cam_hit(input logic [cct_pkg::DAYS_PER_WEEK-1:0] mask,
                                   input logic [2:0] wd,
                                   input logic [cct_pkg::TIME_W-1:0] t,
                                   input logic [cct_pkg::TIME_W-1:0] now);
    return wd <= cct_pkg::WEEKDAY_LAST && mask[wd] && t != cct_pkg::TIME_UNSET && t == now;
  endfunction

  // evaluate all cams once per program cycle; only a new minute is an edge
  always_comb begin
    next_st = st;
    fresh = cal.tick && cal.minute != st.last_min;
    any_on = 1'b0;
    any_off = 1'b0;
    for (int i = 0; i < cct_pkg::CAM_COUNT; i++) begin
      any_on = any_on | (fresh & cam_hit(cams[i].mask, cal.weekday, cams[i].on_min,
                                         cal.minute));
      any_off = any_off | (fresh & cam_hit(cams[i].mask, cal.weekday, cams[i].off_min,
                                           cal.minute));
    end
    if (cal.tick) begin
      next_st.last_min = cal.minute;
      if (pulse_mode) begin
        next_st.out = any_on;
      end else if (any_on) begin
        next_st.out = 1'b1;
      end else if (any_off) begin
        next_st.out = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{out: 1'b0, last_min: cct_pkg::TIME_UNSET};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.out;

  wk_on_sets_a: assert property (@(posedge clk) disable iff (rst)
    cal.tick && any_on |=> st.out) else $error("weekly on-time did not set output");
  wk_off_clears_a: assert property (@(posedge clk) disable iff (rst)
    cal.tick && !pulse_mode && any_off && !any_on |=> !st.out)
    else $error("weekly off-time did not clear output");
  wk_pulse_end_a: assert property (@(posedge clk) disable iff (rst)
    cal.tick && pulse_mode && !any_on |=> !st.out)
    else $error("weekly pulse lasted past one cycle");
  wk_hold_a: assert property (@(posedge clk) disable iff (rst)
    !cal.tick |=> $stable(st.out)) else $error("weekly output moved between cycles");
endmodule

// ==== verilog/cct_yearly.sv ====
/*
  Yearly sub-module: one cam with on/off dates, monthly, yearly, pulse.
  Assumes dates within 2000..2099 as year offsets and a tick pulse.
*/
`timescale 1ns/1ps
module cct_yearly (
  input wire logic clk,
  input wire logic rst,
  cct_cal_if.sink cal,
  input wire cct_pkg::cct_date_t on_date,
  input wire cct_pkg::cct_date_t off_date,
  input wire logic monthly,
  input wire logic yearly,
  input wire logic pulse_mode,
  output logic q
);
  typedef struct packed {
    logic out;
    cct_pkg::cct_date_t last;
  } cct_yr_state_t;

  cct_yr_state_t st;
  cct_yr_state_t next_st;
  logic evt;
  logic in_years;
  logic wrap;
  logic on_hit;
  logic off_hit;

  // dates change only at the first tick of a new day at 00:00
  always_comb begin
    next_st = st;
    evt = cal.tick && cal.midnight && cal.date != st.last;
    in_years = cal.date.year >= on_date.year && cal.date.year <= off_date.year;
    wrap = {off_date.month, off_date.day} < {on_date.month, on_date.day};
    if (monthly) begin
      on_hit = in_years && cal.date.day == on_date.day;
      off_hit = in_years && cal.date.day == off_date.day;
    end else if (yearly) begin
      // a wrapping period never reopens in the final year
      on_hit = in_years && {cal.date.month, cal.date.day} == {on_date.month, on_date.day}
               && !(wrap && cal.date.year == off_date.year);
      off_hit = in_years && {cal.date.month, cal.date.day} == {off_date.month, off_date.day}
                && !(wrap && cal.date.year == on_date.year);
    end else begin
      on_hit = cal.date == on_date;
      off_hit = cal.date == off_date;
    end
    if (cal.tick) begin
      if (pulse_mode) begin
        next_st.out = evt && on_hit;
      end else if (evt && off_hit) begin
        next_st.out = 1'b0;
      end else if (evt && on_hit) begin
        next_st.out = 1'b1;
      end
    end
    if (evt) begin
      next_st.last = cal.date;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{out: 1'b0, last: cct_pkg::DATE_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.out;

  yr_midnight_a: assert property (@(posedge clk) disable iff (rst)
    !pulse_mode && !evt |=> $stable(st.out)) else $error("yearly output moved off midnight");
  yr_range_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st.out) |-> $past(cal.date.year) <= off_date.year && $past(cal.date.year) >= on_date.year)
    else $error("yearly output set outside year range");
  yr_pulse_a: assert property (@(posedge clk) disable iff (rst)
    pulse_mode && cal.tick && !evt |=> !st.out) else $error("yearly pulse too long");
endmodule

// ==== verilog/cct_top.sv ====
/*
  Top of the calendar cam timer: APB register file, calendar fan-out,
  weekly and yearly sub-modules and the registered outputs.
  Assumes the real-time clock inputs and PROGRAM_CYCLE are synchronous
  to SYS_CLK and PROGRAM_CYCLE is a one-cycle pulse per program cycle.
*/
// How it works
// - the weekly part has three cams and one output made from all of them.
// - the weekly output sets at an on-time and clears at an off-time or after a pulse.
// - overlapping cams resolve to the earliest on-time and earliest off-time.
// - each weekly cam has a Monday-to-Sunday day mask that enables it per day.
// - weekly times are minutes of the day, with an unset code that never switches.
// - in pulse mode the weekly output is high for exactly one program cycle.
// - one pulse setting serves all three weekly cams.
// - yearly dates are only accepted for years 2000 to 2099.
// - outside pulse mode the yearly output changes only at midnight of a matching date.
// - yearly dates are year, month, day fields compared one by one.
// - monthly mode switches on each month at the on-day and off at the off-day.
// - yearly mode switches on each year at the on month-day and off at the off month-day.
// - yearly pulse gives one program cycle per on occurrence, repeating per mode.
// - with no mode selected the yearly output spans the on-date to the off-date.
// - a yearly period that wraps runs into next year and never reopens after the last.
// - monthly plus yearly keeps going through the last month of the off year, then stops.
`timescale 1ns/1ps
module cct_top (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PROGRAM_CYCLE,
  input wire logic [6:0] CAL_YEAR,
  input wire logic [3:0] CAL_MONTH,
  input wire logic [4:0] CAL_DAY,
  input wire logic [2:0] CAL_WEEKDAY,
  input wire logic [4:0] CAL_HOUR,
  input wire logic [5:0] CAL_MINUTE,
  output logic WEEKLY_Q,
  output logic YEARLY_Q
);
  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    logic wk_pulse;
    logic y_monthly;
    logic y_yearly;
    logic y_pulse;
    cct_pkg::cct_cams_t cams;
    cct_pkg::cct_date_t yon;
    cct_pkg::cct_date_t yoff;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wq;
    logic yq;
  } cct_top_state_t;

  cct_top_state_t st;
  cct_top_state_t next_st;
  logic wk_q;
  logic yr_q;
  logic setup;
  logic commit;
  logic mapped;
  cct_pkg::cct_date_t wr_date;

  cct_cal_if cal ();

  // ***********************************************
  // field packing
  // ***********************************************
  // date word layout shared by the on and off registers
  function automatic cct_pkg::cct_date_t to_date(input logic [31:0] w);
    cct_pkg::cct_date_t d;
    d.year = w[cct_pkg::DATE_YEAR_LSB +: 7];
    d.month = w[cct_pkg::DATE_MON_LSB +: 4];
    d.day = w[cct_pkg::DATE_DAY_LSB +: 5];
    return d;
  endfunction

  function automatic logic [31:0] from_date(input cct_pkg::cct_date_t d);
    logic [31:0] w;
    w = '0;
    w[cct_pkg::DATE_YEAR_LSB +: 7] = d.year;
    w[cct_pkg::DATE_MON_LSB +: 4] = d.month;
    w[cct_pkg::DATE_DAY_LSB +: 5] = d.day;
    return w;
  endfunction

  function automatic cct_pkg::cct_cam_t to_cam(input logic [31:0] w);
    cct_pkg::cct_cam_t c;
    c.mask = w[cct_pkg::CAM_MASK_LSB +: cct_pkg::DAYS_PER_WEEK];
    c.on_min = w[cct_pkg::CAM_ON_LSB +: cct_pkg::TIME_W];
    c.off_min = w[cct_pkg::CAM_OFF_LSB +: cct_pkg::TIME_W];
    return c;
  endfunction

  function automatic logic [31:0] from_cam(input cct_pkg::cct_cam_t c);
    logic [31:0] w;
    w = '0;
    w[cct_pkg::CAM_MASK_LSB +: cct_pkg::DAYS_PER_WEEK] = c.mask;
    w[cct_pkg::CAM_ON_LSB +: cct_pkg::TIME_W] = c.on_min;
    w[cct_pkg::CAM_OFF_LSB +: cct_pkg::TIME_W] = c.off_min;
    return w;
  endfunction

  // cam index of an address, or CAM_COUNT when it is not a cam
  function automatic int cam_index(input logic [7:0] a);
    case (a)
      cct_pkg::OFS_CAM0: begin
        return 0;
      end
      cct_pkg::OFS_CAM1: begin
        return 1;
      end
      cct_pkg::OFS_CAM2: begin
        return 2;
      end
      default: begin
        return cct_pkg::CAM_COUNT;
      end
    endcase
  endfunction

  // ***********************************************
  // calendar fan-out
  // ***********************************************
  // minute of day is formed once for the weekly part; the yearly part uses midnight
  assign cal.tick = PROGRAM_CYCLE;
  assign cal.minute = 11'(CAL_HOUR * cct_pkg::MIN_PER_HOUR) + 11'(CAL_MINUTE);
  assign cal.weekday = CAL_WEEKDAY;
  assign cal.date = '{year: CAL_YEAR, month: CAL_MONTH, day: CAL_DAY};
  assign cal.midnight = CAL_HOUR == cct_pkg::HOUR_MIDNIGHT && CAL_MINUTE == cct_pkg::MINUTE_ZERO;

  // ***********************************************
  // sub-modules
  // ***********************************************
  cct_weekly u_weekly (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .cal(cal.sink),
    .cams(st.cams),
    .pulse_mode(st.wk_pulse),
    .q(wk_q)
  );

  cct_yearly u_yearly (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .cal(cal.sink),
    .on_date(st.yon),
    .off_date(st.yoff),
    .monthly(st.y_monthly),
    .yearly(st.y_yearly),
    .pulse_mode(st.y_pulse),
    .q(yr_q)
  );

  // ***********************************************
  // APB slave and register file
  // ***********************************************
  // answer is prepared in setup so PREADY and PRDATA come from flops
  always_comb begin
    next_st = st;
    setup = PSEL && !PENABLE;
    commit = PSEL && PENABLE && st.pready;
    wr_date = to_date(PWDATA);
    mapped = cam_index(PADDR) < cct_pkg::CAM_COUNT || PADDR == cct_pkg::OFS_CTRL
             || PADDR == cct_pkg::OFS_YON || PADDR == cct_pkg::OFS_YOFF
             || PADDR == cct_pkg::OFS_STAT;
    next_st.pready = setup;
    next_st.pslverr = setup && !mapped;
    next_st.wq = wk_q;
    next_st.yq = yr_q;
    if (setup) begin
      next_st.prdata = '0;
      if (cam_index(PADDR) < cct_pkg::CAM_COUNT) begin
        next_st.prdata = from_cam(st.cams[cam_index(PADDR)]);
      end
      case (PADDR)
        cct_pkg::OFS_CTRL: begin
          next_st.prdata[cct_pkg::CTRL_WK_PULSE] = st.wk_pulse;
          next_st.prdata[cct_pkg::CTRL_Y_MONTHLY] = st.y_monthly;
          next_st.prdata[cct_pkg::CTRL_Y_YEARLY] = st.y_yearly;
          next_st.prdata[cct_pkg::CTRL_Y_PULSE] = st.y_pulse;
        end
        cct_pkg::OFS_YON: begin
          next_st.prdata = from_date(st.yon);
        end
        cct_pkg::OFS_YOFF: begin
          next_st.prdata = from_date(st.yoff);
        end
        cct_pkg::OFS_STAT: begin
          next_st.prdata[cct_pkg::STAT_WK] = st.wq;
          next_st.prdata[cct_pkg::STAT_YR] = st.yq;
        end
        default: begin
        end
      endcase
    end
    // writes take effect only at the completing edge
    if (commit && PWRITE) begin
      if (cam_index(PADDR) < cct_pkg::CAM_COUNT) begin
        next_st.cams[cam_index(PADDR)] = to_cam(PWDATA);
      end
      case (PADDR)
        cct_pkg::OFS_CTRL: begin
          next_st.wk_pulse = PWDATA[cct_pkg::CTRL_WK_PULSE];
          next_st.y_monthly = PWDATA[cct_pkg::CTRL_Y_MONTHLY];
          next_st.y_yearly = PWDATA[cct_pkg::CTRL_Y_YEARLY];
          next_st.y_pulse = PWDATA[cct_pkg::CTRL_Y_PULSE];
        end
        cct_pkg::OFS_YON: begin
          if (wr_date.year <= cct_pkg::YEAR_MAX) begin
            next_st.yon = wr_date;
          end
        end
        cct_pkg::OFS_YOFF: begin
          if (wr_date.year <= cct_pkg::YEAR_MAX) begin
            next_st.yoff = wr_date;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // single register stage for all top state
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st <= '{wk_pulse: 1'b0, y_monthly: 1'b0, y_yearly: 1'b0, y_pulse: 1'b0,
              cams: {cct_pkg::CAM_COUNT{cct_pkg::CAM_RESET}},
              yon: cct_pkg::DATE_RESET, yoff: cct_pkg::DATE_RESET,
              prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0, wq: 1'b0, yq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign WEEKLY_Q = st.wq;
  assign YEARLY_Q = st.yq;

  // ***********************************************
  // checks
  // ***********************************************
  apb_ready_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    PSEL && !PENABLE |=> PREADY) else $error("no ready one cycle after setup");
  year_reject_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    commit && PWRITE && PADDR == cct_pkg::OFS_YON && wr_date.year > cct_pkg::YEAR_MAX
    |=> $stable(st.yon)) else $error("out of range year accepted");
  out_follow_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ##1 WEEKLY_Q == $past(wk_q) && YEARLY_Q == $past(yr_q))
    else $error("outputs do not follow sub-modules");

  // ***********************************************
  // register file checks
  // ***********************************************
  // refused cycles answer zero data; idle cycles drop ready and error but keep the last PRDATA
  apb_err_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    setup && !mapped |=> PSLVERR && PRDATA == 32'h00000000)
    else $error("unmapped address not refused");

  apb_idle_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !setup |=> !PREADY && !PSLVERR)
    else $error("ready without a setup");

  stat_read_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    setup && PADDR == cct_pkg::OFS_STAT |=> PRDATA[cct_pkg::STAT_WK] == $past(WEEKLY_Q))
    else $error("status read stale");

  // config moves only at a completing write
  cfg_hold_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !commit |=> $stable(st.cams) && $stable(st.yon) && $stable(st.yoff))
    else $error("config changed without a write");

  ctrl_write_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    commit && PWRITE && PADDR == cct_pkg::OFS_CTRL
    |=> st.wk_pulse == $past(PWDATA[cct_pkg::CTRL_WK_PULSE]))
    else $error("pulse setting not written");

  // each accepted write lands whole at its completing edge
  cam_write_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    commit && PWRITE && PADDR == cct_pkg::OFS_CAM0 |=> st.cams[0] == to_cam($past(PWDATA)))
    else $error("cam word not written");

  yon_write_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    commit && PWRITE && PADDR == cct_pkg::OFS_YON && wr_date.year <= cct_pkg::YEAR_MAX
    |=> st.yon == $past(wr_date)) else $error("on date not written");

  // a year past the last is dropped silently
  yoff_reject_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    commit && PWRITE && PADDR == cct_pkg::OFS_YOFF && wr_date.year > cct_pkg::YEAR_MAX
    |=> $stable(st.yoff)) else $error("out of range off year accepted");
endmodule

// ==== tb/cct_user_model.sv ====
/*
  Far-side model: the user circuit program that issues one program
  cycle tick per request and reads both switched outputs in that cycle.
  Assumes tick_req is driven by the bench just after rising edges.
*/
`timescale 1ns/1ps
module cct_user_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick_req,
  input wire logic weekly_q,
  input wire logic yearly_q,
  output logic program_cycle,
  output logic [1:0] seen
);
  // ***********************************************
  // tick source and output sampling
  // ***********************************************
  // a request becomes exactly one tick cycle; the program reads inputs then
  always_ff @(posedge clk) begin
    if (rst) begin
      program_cycle <= 1'b0;
      seen <= 2'h0;
    end else begin
      program_cycle <= tick_req;
      if (program_cycle) begin
        seen <= {yearly_q, weekly_q};
      end
    end
  end
endmodule

// ==== tb/calendar_cam_timer_tb.sv ====
/*
  Self-checking bench of the calendar cam timer: APB access, weekly cams,
  yearly date modes, with ticks issued through the user program model.
  Assumes zero-wait APB and outputs that follow a tick by two edges.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; \
  if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0t got=%h exp=%h", $time, (g), (e)); end end
module calendar_cam_timer_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic prog;
  logic tick_req = 1'b0;
  logic [6:0] year = 7'h05;
  logic [3:0] month = 4'h3;
  logic [4:0] day = 5'h03;
  logic [2:0] wd = 3'h7;
  logic [4:0] hour = 5'h01;
  logic [5:0] minute = 6'h00;
  logic wq;
  logic yq;
  logic [1:0] seen;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int i;
  int j;
  // overlap walk: minutes of day and expected output bit per step
  logic [10:0] wk_min [6] = '{11'h03B, 11'h03C, 11'h046, 11'h063, 11'h064, 11'h06E};
  logic [5:0] wk_exp = 6'h0E;
  // monthly walk: dates and expected output bit per step
  logic [6:0] mo_y [5] = '{7'h08, 7'h08, 7'h0A, 7'h0A, 7'h0B};
  logic [3:0] mo_m [5] = '{4'h2, 4'h2, 4'hB, 4'hB, 4'h1};
  logic [4:0] mo_d [5] = '{5'h01, 5'h05, 5'h01, 5'h05, 5'h01};
  logic [4:0] mo_exp = 5'h05;
  logic [31:0] mo_ctrl [2] = '{32'h2, 32'h6};

  // ***********************************************
  // clock, timeout and instances
  // ***********************************************
  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  // a hang is cut short well past the expected few hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end

  cct_top dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PROGRAM_CYCLE(prog), .CAL_YEAR(year), .CAL_MONTH(month),
    .CAL_DAY(day), .CAL_WEEKDAY(wd), .CAL_HOUR(hour), .CAL_MINUTE(minute),
    .WEEKLY_Q(wq), .YEARLY_Q(yq));

  cct_user_model partner (.clk(sys_clk), .rst(sys_rst), .tick_req(tick_req),
    .weekly_q(wq), .yearly_q(yq), .program_cycle(prog), .seen(seen));

  // ***********************************************
  // access tasks
  // ***********************************************
  // one APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // present a calendar moment with one tick, then wait until it shows
  task automatic tick(input logic [2:0] w, input logic [6:0] y, input logic [3:0] m,
                      input logic [4:0] dd, input logic [10:0] mod);
    @(posedge sys_clk);
    wd <= w;
    year <= y;
    month <= m;
    day <= dd;
    hour <= 5'(mod / cct_pkg::MIN_PER_HOUR);
    minute <= 6'(mod % cct_pkg::MIN_PER_HOUR);
    tick_req <= 1'b1;
    @(posedge sys_clk);
    tick_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [31:0] camw(logic [6:0] mk, logic [10:0] on, logic [10:0] off);
    return (32'(mk) << cct_pkg::CAM_MASK_LSB) | (32'(on) << cct_pkg::CAM_ON_LSB) |
      (32'(off) << cct_pkg::CAM_OFF_LSB);
  endfunction

  function automatic logic [31:0] datew(logic [6:0] y, logic [3:0] m, logic [4:0] d);
    return (32'(y) << cct_pkg::DATE_YEAR_LSB) | (32'(m) << cct_pkg::DATE_MON_LSB) |
      (32'(d) << cct_pkg::DATE_DAY_LSB);
  endfunction

  // verdict in one place; counts go out first
  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ***********************************************
  // main sequence
  // ***********************************************
  // weekly ticks use weekday 7 on yearly steps so no cam can match there
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, cct_pkg::OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, cct_pkg::OFS_CAM1, 32'h0);
    `CHK(rd, camw(7'h00, cct_pkg::TIME_UNSET, cct_pkg::TIME_UNSET))
    apb(1'b0, cct_pkg::OFS_YOFF, 32'h0);
    `CHK(rd, datew(7'h00, 4'h1, 5'h01))
    apb(1'b1, 8'h1C, 32'hFFFFFFFF);
    `CHK(er, 1'b1)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    // overlapping cams: earliest on and earliest off win
    apb(1'b1, cct_pkg::OFS_CAM0, camw(7'h7F, 11'h03C, 11'h078));
    apb(1'b1, cct_pkg::OFS_CAM1, camw(7'h7F, 11'h046, 11'h06E));
    apb(1'b1, cct_pkg::OFS_CAM2, camw(7'h7F, 11'h050, 11'h064));
    for (i = 0; i < 6; i++) begin
      tick(3'h0, 7'h05, 4'h3, 5'h03, wk_min[i]);
      `CHK(wq, wk_exp[i])
    end
    // day mask Monday plus Sunday only
    apb(1'b1, cct_pkg::OFS_CAM0, camw(7'h41, 11'h186, 11'h1E0));
    tick(3'h1, 7'h05, 4'h3, 5'h03, 11'h186);
    `CHK(wq, 1'b0)
    tick(3'h6, 7'h05, 4'h3, 5'h03, 11'h185); // a repeated minute never fires
    tick(3'h6, 7'h05, 4'h3, 5'h03, 11'h186);
    `CHK(wq, 1'b1)
    apb(1'b0, cct_pkg::OFS_STAT, 32'h0);
    `CHK(rd[cct_pkg::STAT_WK], 1'b1)
    tick(3'h6, 7'h05, 4'h3, 5'h03, 11'h1E0);
    `CHK(wq, 1'b0)
    // unset off edge never clears, unset on edge never sets
    apb(1'b1, cct_pkg::OFS_CAM0, camw(7'h41, 11'h186, cct_pkg::TIME_UNSET));
    tick(3'h0, 7'h05, 4'h3, 5'h03, 11'h186);
    tick(3'h0, 7'h05, 4'h3, 5'h03, 11'h59F);
    `CHK(wq, 1'b1)
    apb(1'b1, cct_pkg::OFS_CAM0, camw(7'h41, cct_pkg::TIME_UNSET, 11'h258));
    tick(3'h0, 7'h05, 4'h3, 5'h03, 11'h258);
    tick(3'h0, 7'h05, 4'h3, 5'h03, 11'h186);
    `CHK(wq, 1'b0)
    // one shared pulse setting acts on the third cam
    apb(1'b1, cct_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, cct_pkg::OFS_CAM2, camw(7'h7F, 11'h2BC, cct_pkg::TIME_UNSET));
    tick(3'h2, 7'h05, 4'h3, 5'h03, 11'h2BC);
    `CHK({seen[0], wq}, 2'h1)
    tick(3'h2, 7'h05, 4'h3, 5'h03, 11'h2BD);
    `CHK({seen[0], wq}, 2'h2)
    // plain date span, switching only at midnight
    apb(1'b1, cct_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, cct_pkg::OFS_YON, datew(7'h08, 4'h6, 5'h01));
    apb(1'b1, cct_pkg::OFS_YOFF, datew(7'h0A, 4'h8, 5'h1F));
    tick(3'h7, 7'h08, 4'h6, 5'h01, 11'h258);
    `CHK(yq, 1'b0)
    tick(3'h7, 7'h08, 4'h6, 5'h01, 11'h000);
    `CHK(yq, 1'b1)
    tick(3'h7, 7'h09, 4'h8, 5'h1F, 11'h000);
    `CHK(yq, 1'b1)
    tick(3'h7, 7'h0A, 4'h8, 5'h1F, 11'h000);
    `CHK(yq, 1'b0)
    // yearly mode with a period wrapping into the next year
    apb(1'b1, cct_pkg::OFS_CTRL, 32'h4);
    apb(1'b1, cct_pkg::OFS_YON, datew(7'h08, 4'hC, 5'h0F));
    apb(1'b1, cct_pkg::OFS_YOFF, datew(7'h0A, 4'h1, 5'h07));
    tick(3'h7, 7'h08, 4'hC, 5'h0F, 11'h000);
    `CHK(yq, 1'b1)
    tick(3'h7, 7'h09, 4'h1, 5'h07, 11'h000);
    `CHK(yq, 1'b0)
    tick(3'h7, 7'h09, 4'hC, 5'h0F, 11'h000);
    `CHK(yq, 1'b1)
    tick(3'h7, 7'h0A, 4'h1, 5'h07, 11'h000);
    tick(3'h7, 7'h0A, 4'hC, 5'h0F, 11'h000);
    `CHK(yq, 1'b0)
    // monthly alone, then monthly with yearly
    apb(1'b1, cct_pkg::OFS_YON, datew(7'h08, 4'h1, 5'h01));
    apb(1'b1, cct_pkg::OFS_YOFF, datew(7'h0A, 4'h1, 5'h05));
    for (j = 0; j < 2; j++) begin
      apb(1'b1, cct_pkg::OFS_CTRL, mo_ctrl[j]);
      for (i = 0; i < 5; i++) begin
        tick(3'h7, mo_y[i], mo_m[i], mo_d[i], 11'h000);
        `CHK(yq, mo_exp[i])
      end
    end
    // yearly pulse, then an out-of-range year write is dropped
    apb(1'b1, cct_pkg::OFS_CTRL, 32'hC);
    apb(1'b1, cct_pkg::OFS_YON, datew(7'h08, 4'h3, 5'h0F));
    apb(1'b1, cct_pkg::OFS_YOFF, datew(7'h0A, 4'hC, 5'h1F));
    tick(3'h7, 7'h0A, 4'h3, 5'h0F, 11'h000);
    `CHK(yq, 1'b1)
    tick(3'h7, 7'h0A, 4'h3, 5'h10, 11'h000);
    `CHK({seen[1], yq}, 2'h2)
    tick(3'h7, 7'h0B, 4'h3, 5'h0F, 11'h000);
    `CHK(yq, 1'b0)
    apb(1'b1, cct_pkg::OFS_YON, datew(7'h64, 4'h3, 5'h0F));
    apb(1'b0, cct_pkg::OFS_YON, 32'h0);
    `CHK(rd, datew(7'h08, 4'h3, 5'h0F))
    conclude();
  end
endmodule
